// ### pkg/hoc_pkg.sv
package hoc_pkg;

    // configuration byte offsets
    localparam logic [3:0] OFF_OPT_ONE = 4'h6;
    localparam logic [3:0] OFF_OPT_TWO = 4'h7;
    localparam logic [3:0] OFF_FIXED_MASK = 4'h8;
    localparam logic [3:0] OFF_SP_OFF_MASK = 4'h9;
    localparam logic [3:0] OFF_BP_OFF_MASK = 4'hA;
    localparam logic [3:0] OFF_LAST = 4'hF;

    // field positions in option byte one
    localparam int POS_POWER_SOURCE = 7;
    localparam int POS_FULL_SPEED_ONLY = 5;
    localparam int POS_EOP_SUPPRESS = 3;
    localparam int POS_SENSE_HI = 2;
    localparam int POS_SENSE_LO = 1;

    // field positions in option byte two
    localparam int POS_DYNAMIC = 7;
    localparam int POS_DELAY_HI = 5;
    localparam int POS_DELAY_LO = 4;
    localparam int POS_COMPOUND = 3;

    // writable bits per byte; reserved bits are stored as zero
    localparam logic [7:0] MASK_OPT_ONE = 8'hAE;
    localparam logic [7:0] MASK_OPT_TWO = 8'hB8;
    localparam logic [7:0] MASK_PORTS = 8'h06;

    // values after reset
    localparam logic [7:0] RST_OPT_ONE_SELF = 8'h88;
    localparam logic [7:0] RST_OPT_ONE_BUS = 8'h0C;
    localparam logic [7:0] RST_OPT_TWO = 8'h90;
    localparam logic [7:0] RST_PORT_MASK = 8'h00;

    // over-current delay figures in microseconds (the first in tenths of a millisecond) and cycles at 125 MHz
    localparam int CLK_MHZ = 125;
    localparam int OC_DELAY_0_US_X10 = 1;
    localparam int OC_DELAY_1_US = 2000;
    localparam int OC_DELAY_2_US = 4000;
    localparam int OC_DELAY_3_US = 6000;
    // 0.1 ms is 100 us, so tenths of a millisecond times 1000 us per ms
    localparam int OC_CYC_0 = OC_DELAY_0_US_X10 * CLK_MHZ * 1000 / 10;
    localparam int OC_CYC_1 = OC_DELAY_1_US * CLK_MHZ;
    localparam int OC_CYC_2 = OC_DELAY_2_US * CLK_MHZ;
    localparam int OC_CYC_3 = OC_DELAY_3_US * CLK_MHZ;

    // over-current sensing modes
    typedef enum logic [1:0] {
        HOC_SENSE_GANGED = 2'h0,
        HOC_SENSE_NONE_CFG = 2'h1,
        HOC_SENSE_OFF = 2'h2
    } hoc_sense_e;

    // decoded hub options presented to the hub core
    typedef struct packed {
        logic self_powered;
        logic full_speed_only;
        logic frame_end_packet_suppress;
        hoc_sense_e overcurrent_sense_mode;
        logic [1:0] overcurrent_delay_select;
        logic compound;
        logic [1:0] fixed_ports;
        logic [1:0] port_off;
    } hoc_opts_s;

    // configuration byte write from the loader
    typedef struct packed {
        logic valid;
        logic [3:0] offset;
        logic [7:0] data;
    } hoc_wr_s;

endpackage

// ### src/hoc_option_decoder.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - option byte one bit 7 picks bus power at 0 and self power at 1.
// - with dynamic switching on, the local power pin replaces that stored bit.
// - option byte one bit 5 at 1 forbids high-speed attach, full speed only.
// - option byte one bit 3 at 0 allows the end-of-frame packet, at 1 suppresses it.
// - option byte one bits 2:1 give ganged sensing at 00, reserved 01, none at 1x.
// - option byte two bits 5:4 pick an over-current delay of 0.1, 2, 4 or 6 ms.
// - option byte two bit 3 at 1 marks the hub as part of a compound device.
// - the fixed device mask flags ports 1 and 2 on bits 1 and 2, others zero.
// - while self powered, ports set in the self powered off mask stay disabled.
// - while bus powered, ports set in the bus powered off mask stay disabled.
// - with external configuration, all bytes load before upstream attach is allowed.
// - with no external load, byte one is 88 or 0C by strap, byte two is 90.
////////////////////////////////////////////////////////////////////////////////
module hoc_option_decoder (
    input wire logic clk, // core clock, 125 MHz
    input wire logic arst_n, // async reset, active low
    input wire logic self_power_strap, // strap level, 1 = self powered defaults
    input wire logic ext_config_en, // external configuration selected, held static
    input wire hoc_pkg::hoc_wr_s cfg_wr, // byte write from eeprom or smbus loader
    input wire logic cfg_done, // loader finished, one-cycle pulse
    input wire logic [3:0] cfg_rd_offset, // byte read offset
    input wire logic local_power_present_pin, // local supply indication, async pin
    output logic [7:0] cfg_rd_data, // byte read data, one cycle after offset
    output hoc_pkg::hoc_opts_s opts, // decoded options
    output logic attach_ok // upstream attach permitted
);
    ////////////////////////////////////////////////////////////////////////////
    logic local_pwr_s;
    logic strap_seen_q;
    logic loaded_q;
    logic [7:0] opt_one_q;
    logic [7:0] opt_two_q;
    logic [7:0] fixed_mask_q;
    logic [7:0] sp_off_q;
    logic [7:0] bp_off_q;

    hoc_sync u_pwr_sync (
        .clk(clk),
        .arst_n(arst_n),
        .d(local_power_present_pin),
        .q(local_pwr_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // write strobes per offset
    wire wr_one = cfg_wr.valid && (cfg_wr.offset == hoc_pkg::OFF_OPT_ONE);
    wire wr_two = cfg_wr.valid && (cfg_wr.offset == hoc_pkg::OFF_OPT_TWO);
    wire wr_fix = cfg_wr.valid && (cfg_wr.offset == hoc_pkg::OFF_FIXED_MASK);
    wire wr_sp = cfg_wr.valid && (cfg_wr.offset == hoc_pkg::OFF_SP_OFF_MASK);
    wire wr_bp = cfg_wr.valid && (cfg_wr.offset == hoc_pkg::OFF_BP_OFF_MASK);
    wire [7:0] one_dflt = self_power_strap ? hoc_pkg::RST_OPT_ONE_SELF
                                           : hoc_pkg::RST_OPT_ONE_BUS;

    // strap sampled on the first clock after release, never at reset itself
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            strap_seen_q <= 1'b0;
            opt_one_q <= hoc_pkg::RST_OPT_ONE_SELF;
            opt_two_q <= hoc_pkg::RST_OPT_TWO;
            fixed_mask_q <= hoc_pkg::RST_PORT_MASK;
            sp_off_q <= hoc_pkg::RST_PORT_MASK;
            bp_off_q <= hoc_pkg::RST_PORT_MASK;
        end else begin
            strap_seen_q <= 1'b1;
            if (!strap_seen_q) begin
                opt_one_q <= one_dflt;
            end else if (wr_one) begin
                opt_one_q <= cfg_wr.data & hoc_pkg::MASK_OPT_ONE;
            end
            if (wr_two) begin
                opt_two_q <= cfg_wr.data & hoc_pkg::MASK_OPT_TWO;
            end
            if (wr_fix) begin
                fixed_mask_q <= cfg_wr.data & hoc_pkg::MASK_PORTS;
            end
            if (wr_sp) begin
                sp_off_q <= cfg_wr.data & hoc_pkg::MASK_PORTS;
            end
            if (wr_bp) begin
                bp_off_q <= cfg_wr.data & hoc_pkg::MASK_PORTS;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // with external configuration, attach held off until the loader reports all bytes read
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            loaded_q <= 1'b0;
        end else if (cfg_done) begin
            loaded_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // field decode; reserved bits never reach the outputs
    wire stored_self = opt_one_q[hoc_pkg::POS_POWER_SOURCE];
    wire dynamic_en = opt_two_q[hoc_pkg::POS_DYNAMIC];
    // pin wins over the stored bit when dynamic switching is on
    wire power_source_select = dynamic_en ? local_pwr_s : stored_self;
    wire [1:0] sense_code = opt_one_q[hoc_pkg::POS_SENSE_HI:hoc_pkg::POS_SENSE_LO];
    // 01 is reserved and decodes to its own no-configured-mode value
    wire hoc_pkg::hoc_sense_e sense_mode =
        sense_code[1] ? hoc_pkg::HOC_SENSE_OFF :
        sense_code[0] ? hoc_pkg::HOC_SENSE_NONE_CFG :
                        hoc_pkg::HOC_SENSE_GANGED;
    wire [1:0] off_sel = power_source_select ? sp_off_q[2:1] : bp_off_q[2:1];
    wire attach_d = ext_config_en ? loaded_q : strap_seen_q;

    hoc_pkg::hoc_opts_s opts_d;
    always_comb begin
        opts_d.self_powered = power_source_select;
        opts_d.full_speed_only = opt_one_q[hoc_pkg::POS_FULL_SPEED_ONLY];
        opts_d.frame_end_packet_suppress = opt_one_q[hoc_pkg::POS_EOP_SUPPRESS];
        opts_d.overcurrent_sense_mode = sense_mode;
        opts_d.overcurrent_delay_select =
            opt_two_q[hoc_pkg::POS_DELAY_HI:hoc_pkg::POS_DELAY_LO];
        opts_d.compound = opt_two_q[hoc_pkg::POS_COMPOUND];
        opts_d.fixed_ports = fixed_mask_q[2:1];
        opts_d.port_off = off_sel;
    end

    // read mux; unmapped offsets read zero
    wire [7:0] rd_d =
        (cfg_rd_offset == hoc_pkg::OFF_OPT_ONE) ? opt_one_q :
        (cfg_rd_offset == hoc_pkg::OFF_OPT_TWO) ? opt_two_q :
        (cfg_rd_offset == hoc_pkg::OFF_FIXED_MASK) ? fixed_mask_q :
        (cfg_rd_offset == hoc_pkg::OFF_SP_OFF_MASK) ? sp_off_q :
        (cfg_rd_offset == hoc_pkg::OFF_BP_OFF_MASK) ? bp_off_q : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // registered outputs
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            opts <= '0;
            attach_ok <= 1'b0;
            cfg_rd_data <= 8'h00;
        end else begin
            opts <= opts_d;
            attach_ok <= attach_d;
            cfg_rd_data <= rd_d;
        end
    end
endmodule // hoc_option_decoder

// ### src/hoc_sync.sv
`timescale 1ns/100ps
// two-stage synchroniser for a pin level
module hoc_sync (
    input wire logic clk, // core clock
    input wire logic arst_n, // async reset, active low
    input wire logic d, // asynchronous level
    output logic q // synchronised level
);
    logic meta_q;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // hoc_sync

// ### tb/hoc_loader_model.sv
`timescale 1ns/100ps
// stands in for the eeprom or smbus loader that feeds configuration bytes
module hoc_loader_model (
    input wire logic clk, // core clock
    output hoc_pkg::hoc_wr_s cfg_wr, // byte write
    output logic cfg_done // load finished
);
    initial begin
        cfg_wr = '0;
        cfg_done = 1'b0;
    end
    // one byte per call; idle fields scrambled so nothing leans on stale values
    task automatic put(input logic [3:0] off, input logic [7:0] val);
        @(negedge clk);
        cfg_wr = '{1'b1, off, val};
        @(negedge clk);
        cfg_wr = '{1'b0, ~off, ~val};
    endtask
    // end of load, one cycle pulse
    task automatic finish();
        @(negedge clk);
        cfg_done = 1'b1;
        @(negedge clk);
        cfg_done = 1'b0;
    endtask
endmodule // hoc_loader_model

// ### tb/hoc_option_decoder_properties.sv
`timescale 1ns/100ps
// pin-level checks on the option decoder
module hoc_option_decoder_properties (
    input wire logic clk, // clock
    input wire logic arst_n, // reset
    input wire logic self_power_strap, // strap
    input wire logic ext_config_en, // ext load
    input wire hoc_pkg::hoc_wr_s cfg_wr, // write
    input wire logic cfg_done, // load done
    input wire logic [3:0] cfg_rd_offset, // rd offset
    input wire logic local_power_present_pin, // pin
    input wire logic [7:0] cfg_rd_data, // rd data
    input wire hoc_pkg::hoc_opts_s opts, // options
    input wire logic attach_ok // attach
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    // lone writes only: a second write to the byte would move the decode again
    wire w6 = cfg_wr.valid && cfg_wr.offset == 4'h6;
    wire w7 = cfg_wr.valid && cfg_wr.offset == 4'h7;
    wire w8 = cfg_wr.valid && cfg_wr.offset == 4'h8;
    property p_fso; w6 ##1 !w6 |=> opts.full_speed_only == $past(cfg_wr.data[5], 2); endproperty
    property p_eop;
        w6 ##1 !w6 |=> opts.frame_end_packet_suppress == $past(cfg_wr.data[3], 2);
    endproperty
    property p_sns; w6 ##1 !w6 |=> opts.overcurrent_sense_mode ==
        {$past(cfg_wr.data[2], 2), $past(cfg_wr.data[2:1], 2) == 2'b01}; endproperty
    property p_two; w7 ##1 !w7 |=> {opts.overcurrent_delay_select, opts.compound} ==
        $past(cfg_wr.data[5:3], 2); endproperty
    property p_fix; w8 ##1 !w8 |=> opts.fixed_ports == $past(cfg_wr.data[2:1], 2); endproperty
    property p_unm; cfg_rd_offset > 4'hA || cfg_rd_offset < 4'h6 |=> cfg_rd_data == 8'h00;
    endproperty
    property p_rsv; cfg_rd_offset == 4'h7 |=> cfg_rd_data[2:0] == 3'h0 && !cfg_rd_data[6];
    endproperty
    property p_att; ext_config_en && cfg_done |-> ##2 attach_ok; endproperty
    property p_early; ext_config_en && $rose(attach_ok) |-> $past(cfg_done, 2); endproperty
    property p_rst; $rose(arst_n) |=> ##1 opts.frame_end_packet_suppress && opts.overcurrent_sense_mode
        == ($past(self_power_strap) ? 2'h0 : 2'h2) && opts.overcurrent_delay_select == 2'h1;
    endproperty
    a_fso: assert property (p_fso) else $error("speed decode wrong");
    a_eop: assert property (p_eop) else $error("eop decode wrong");
    a_sns: assert property (p_sns) else $error("sense decode wrong");
    a_two: assert property (p_two) else $error("byte two decode wrong");
    a_fix: assert property (p_fix) else $error("fixed port decode wrong");
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    a_rsv: assert property (p_rsv) else $error("reserved bits kept");
    a_att: assert property (p_att) else $error("attach late");
    a_early: assert property (p_early) else $error("attach early");
    a_rst: assert property (p_rst) else $error("reset defaults wrong");
    c_wr: cover property (w6 ##2 opts.full_speed_only);
    c_att: cover property ($rose(attach_ok));
    c_pin: cover property ($rose(opts.self_powered));
endmodule // hoc_option_decoder_properties
bind hoc_option_decoder hoc_option_decoder_properties u_props (.*);

// ### tb/hub_option_config_decoder_tb.sv
`timescale 1ns/100ps
module hub_option_config_decoder_tb;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic strap = 1'b1;
    logic pin = 1'b1;
    logic ext = 1'b0;
    logic [3:0] off = 4'h0;
    logic [7:0] rdat;
    logic att;
    logic done;
    hoc_pkg::hoc_opts_s o;
    hoc_pkg::hoc_wr_s wr;
    int failures = 0;
    int checked = 0;
    // clock, loader and block
    always #4 clk = ~clk;
    hoc_loader_model LDR (.clk(clk), .cfg_wr(wr), .cfg_done(done));
    hoc_option_decoder DUT (.clk(clk), .arst_n(arst_n), .self_power_strap(strap),
        .ext_config_en(ext), .cfg_wr(wr), .cfg_done(done), .cfg_rd_offset(off),
        .local_power_present_pin(pin), .cfg_rd_data(rdat), .opts(o), .attach_ok(att));
    ////////////////////////////////////////
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // offset set on a falling edge, data settled one edge later
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(negedge clk);
        off = a;
        @(negedge clk);
        chk("read", e, rdat);
    endtask
    task automatic t_defaults();
        for (int s = 0; s < 2; s++) begin
            arst_n = 1'b0;
            strap = s[0];
            ext = s[0];
            repeat (3) @(negedge clk);
            arst_n = 1'b1;
            repeat (2) @(negedge clk);
            chk("attach", s ? 8'h00 : 8'h01, {7'h0, att});
            rd(4'h6, s ? 8'h88 : 8'h0C);
            rd(4'h7, 8'h90);
            rd(4'hA, 8'h00);
        end
    endtask
    // attach held off until the load ends, then sticks
    task automatic t_attach();
        chk("attach", 8'h00, {7'h0, att});
        LDR.finish();
        chk("attach", 8'h00, {7'h0, att});
        repeat (3) @(negedge clk);
        chk("attach", 8'h01, {7'h0, att});
    endtask
    task automatic t_byte_one();
        logic [7:0] v [5] = '{8'hFF, 8'h02, 8'h00, 8'h04, 8'h28};
        foreach (v[i]) begin
            LDR.put(4'h6, v[i]);
            rd(4'h6, v[i] & 8'hAE);
            chk("byte1", {4'h0, v[i][5], v[i][3], v[i][2], v[i][2:1] == 2'b01}, {4'h0,
                o.full_speed_only, o.frame_end_packet_suppress, o.overcurrent_sense_mode});
        end
    endtask
    // stored source bit, then the pin once switching is on
    task automatic t_power();
        LDR.put(4'h9, 8'hFF);
        LDR.put(4'hA, 8'h04);
        LDR.put(4'h7, 8'h00);
        rd(4'h9, 8'h06);
        for (int b = 0; b < 2; b++) begin
            LDR.put(4'h6, {b[0], 7'h0});
            @(negedge clk);
            chk("power", {5'h0, b[0], 1'b1, b[0]}, {5'h0, o.self_powered, o.port_off});
        end
        LDR.put(4'h7, 8'h80);
        pin = 1'b0;
        repeat (5) @(negedge clk);
        chk("pin", 8'h02, {5'h0, o.self_powered, o.port_off});
    endtask
    task automatic t_byte_two();
        for (int c = 0; c < 4; c++) begin
            LDR.put(4'h7, {2'b11, c[1:0], c[0], 3'h7});
            rd(4'h7, {2'b10, c[1:0], c[0], 3'h0});
            chk("byte2", {5'h0, c[1:0], c[0]}, {5'h0, o.overcurrent_delay_select, o.compound});
        end
        LDR.put(4'h8, 8'hFB);
        rd(4'h8, 8'h02);
        chk("fixed", 8'h01, {6'h0, o.fixed_ports});
        LDR.put(4'hF, 8'hFF);
        rd(4'hF, 8'h00);
    endtask
    ////////////////////////////////////////
    initial begin
        t_defaults();
        t_attach();
        t_byte_one();
        t_power();
        t_byte_two();
        report_and_stop();
    end
    // hang guard, far beyond the fewer than a hundred cycles the run needs
    initial begin
        #100000;
        failures++;
        report_and_stop();
    end
    task automatic report_and_stop();
        if (failures == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
endmodule // hub_option_config_decoder_tb
